// >>> hdl/nvbap_core.sv
/*
  Processor-side end: turns byte and 16-bit commands into I/O register
  accesses, low byte first, and holds off new commands while the port stalls.
  Assumes the command source keeps a command steady until it is taken.
*/
`timescale 1ns/1ps
`default_nettype none
module nvbap_core
    import nvbap_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        resetn_in,
    nvbap_if.core            bus,
    input  wire logic        cmd_valid_in,
    input  wire logic [1:0]  cmd_kind_in,
    input  wire logic        cmd_wide_in,
    input  wire logic        cmd_io_in,
    input  wire logic [7:0]  cmd_addr_in,
    input  wire logic [15:0] cmd_wdata_in,
    input  wire logic [2:0]  cmd_bit_in,
    output var  logic        cmd_ready_out,
    output var  logic        rsp_valid_out,
    output var  logic [15:0] rsp_data_out
);
    nvbap_core_state_t state;
    nvbap_core_state_t next_state;
    logic [7:0]  hi_byte;
    logic [7:0]  next_hi_byte;
    logic        wide;
    logic        next_wide;
    logic        is_rd;
    logic        next_is_rd;
    logic        hi_phase;
    logic        next_hi_phase;
    logic        next_ready;
    logic        next_rsp_valid;
    logic [15:0] next_rsp_data;
    logic        next_io_rd;
    logic        next_io_wr;
    logic        next_io_bset;
    logic        next_io_bclr;
    logic        next_io_space;
    logic [7:0]  next_io_addr;
    logic [7:0]  next_io_wdata;
    logic [2:0]  next_io_bit;
    logic [7:0]  ea;
    logic        wr_kind;

    always_comb
    begin
        next_state     = state;
        next_hi_byte   = hi_byte;
        next_wide      = wide;
        next_is_rd     = is_rd;
        next_hi_phase  = hi_phase;
        next_rsp_valid = 1'b0;
        next_rsp_data  = rsp_data_out;
        next_io_rd     = 1'b0;
        next_io_wr     = 1'b0;
        next_io_bset   = 1'b0;
        next_io_bclr   = 1'b0;
        next_io_space  = bus.io_space;
        next_io_addr   = bus.io_addr;
        next_io_wdata  = bus.io_wdata;
        next_io_bit    = bus.io_bit;
        ea = nvbap_eff_addr(cmd_addr_in, cmd_io_in);
        wr_kind = cmd_kind_in != ACC_RD;
        case (state)
            CS_IDLE:
            begin
                if (cmd_valid_in && cmd_ready_out)
                begin
                    if (wr_kind && !nvbap_mapped(ea))
                        next_rsp_valid = 1'b1;
                    else
                    begin
                        next_io_rd    = cmd_kind_in == ACC_RD;
                        next_io_wr    = cmd_kind_in == ACC_WR;
                        next_io_bset  = cmd_kind_in == ACC_BSET;
                        next_io_bclr  = cmd_kind_in == ACC_BCLR;
                        next_io_space = cmd_io_in;
                        next_io_addr  = cmd_addr_in;
                        next_io_wdata = cmd_wdata_in[7:0] & nvbap_wmask(ea);
                        next_io_bit   = cmd_bit_in;
                        next_hi_byte  = cmd_wdata_in[15:8] & nvbap_wmask(ea + 8'h01);
                        next_wide     = cmd_wide_in && cmd_kind_in inside {ACC_RD, ACC_WR};
                        next_is_rd    = cmd_kind_in == ACC_RD;
                        next_state    = CS_ONE;
                    end
                end
            end
            CS_ONE:
            begin
                // Read data stands only from the edge after the access, so
                // capture waits for the next state.
                if (wide)
                begin
                    next_io_rd    = is_rd;
                    next_io_wr    = !is_rd;
                    next_io_addr  = bus.io_addr + 8'h01;
                    next_io_wdata = hi_byte;
                end
                next_state = CS_TWO;
            end
            CS_TWO:
            begin
                if (is_rd && hi_phase)
                    next_rsp_data[15:8] = bus.io_rdata;
                else if (is_rd)
                    next_rsp_data[7:0] = bus.io_rdata;
                if (wide && !hi_phase)
                    next_hi_phase = 1'b1;
                else
                begin
                    next_hi_phase  = 1'b0;
                    next_rsp_valid = 1'b1;
                    next_state     = CS_IDLE;
                end
            end
            default: next_state = CS_IDLE;
        endcase
        next_ready = next_state == CS_IDLE && !bus.io_stall && !next_rsp_valid;
    end

    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state         <= CS_IDLE;
            hi_byte       <= 8'h00;
            wide          <= 1'b0;
            is_rd         <= 1'b0;
            hi_phase      <= 1'b0;
            cmd_ready_out <= 1'b0;
            rsp_valid_out <= 1'b0;
            rsp_data_out  <= 16'h0000;
            bus.io_rd     <= 1'b0;
            bus.io_wr     <= 1'b0;
            bus.io_bset   <= 1'b0;
            bus.io_bclr   <= 1'b0;
            bus.io_space  <= 1'b0;
            bus.io_addr   <= 8'h00;
            bus.io_wdata  <= 8'h00;
            bus.io_bit    <= 3'h0;
        end
        else
        begin
            state         <= next_state;
            hi_byte       <= next_hi_byte;
            wide          <= next_wide;
            is_rd         <= next_is_rd;
            hi_phase      <= next_hi_phase;
            cmd_ready_out <= next_ready;
            rsp_valid_out <= next_rsp_valid;
            rsp_data_out  <= next_rsp_data;
            bus.io_rd     <= next_io_rd;
            bus.io_wr     <= next_io_wr;
            bus.io_bset   <= next_io_bset;
            bus.io_bclr   <= next_io_bclr;
            bus.io_space  <= next_io_space;
            bus.io_addr   <= next_io_addr;
            bus.io_wdata  <= next_io_wdata;
            bus.io_bit    <= next_io_bit;
        end
    end
endmodule : nvbap_core
`default_nettype wire

// >>> hdl/nvbap_device.sv
/*
  EEPROM byte access port: control, data, address pair, temporary byte and
  done flag registers, the self-timed write engine and the array itself.
  Assumes accesses come from registered signals of the core end, at most one
  per cycle, and that por_resetn_in is low only while the supply is bad.
*/
`timescale 1ns/1ps
`default_nettype none
module nvbap_device
    import nvbap_pkg::*;
#(
    parameter int DEPTH        = DEFAULT_DEPTH,
    parameter int ATOMIC_TICKS = ATOMIC_CYCLES,
    parameter int SPLIT_TICKS  = SPLIT_CYCLES
) (
    input  wire logic    core_clk_in,
    input  wire logic    resetn_in,
    input  wire logic    por_resetn_in,
    nvbap_if.device      bus,
    output var  logic    nvm_busy_out
);
    localparam int AW = $clog2(DEPTH);

    initial
    begin
        if (DEPTH != 256 && DEPTH != 512)
            $error("DEPTH must be 256 or 512");
        if (ATOMIC_TICKS < 1 || ATOMIC_TICKS >= (1 << TIMER_W))
            $error("ATOMIC_TICKS out of range");
        if (SPLIT_TICKS < 1 || SPLIT_TICKS >= (1 << TIMER_W))
            $error("SPLIT_TICKS out of range");
    end

    logic [7:0]         mem [DEPTH];
    logic [ADDR_W-1:0]  nvm_byte_address;
    logic [ADDR_W-1:0]  next_nvm_byte_address;
    logic [1:0]         program_operation_select;
    logic [1:0]         next_program_operation_select;
    logic               rdy_int_en;
    logic               next_rdy_int_en;
    logic               write_arm_bit;
    logic               next_write_arm_bit;
    logic [2:0]         arm_cnt;
    logic [2:0]         next_arm_cnt;
    logic [7:0]         nvm_data_byte;
    logic [7:0]         next_nvm_data_byte;
    logic [7:0]         temp_byte;
    logic [7:0]         next_temp_byte;
    logic               done_flag;
    logic               next_done_flag;
    logic [2:0]         stall_cnt;
    logic [2:0]         next_stall_cnt;
    logic               stall;
    logic               next_stall;
    logic [7:0]         rdata;
    logic [7:0]         next_rdata;
    logic               busy;
    logic               next_busy;
    logic [TIMER_W-1:0] tcnt;
    logic [TIMER_W-1:0] next_tcnt;
    logic [AW-1:0]      w_addr;
    logic [AW-1:0]      next_w_addr;
    logic [7:0]         w_data;
    logic [7:0]         next_w_data;
    logic [1:0]         w_mode;
    logic [1:0]         next_w_mode;
    logic               start;
    logic               commit;
    logic [7:0]         ea;
    logic               wr_any;
    logic [7:0]         wm;
    logic [7:0]         wv;
    logic               strobe_hit;
    logic               read_hit;

    assign bus.io_rdata  = rdata;
    assign bus.io_stall  = stall;
    assign nvm_busy_out  = busy;

    always_comb
    begin
        ea = nvbap_eff_addr(bus.io_addr, bus.io_space);
        wr_any = bus.io_wr
               | ((bus.io_bset | bus.io_bclr) & bus.io_space & (bus.io_addr < BIT_OP_LIMIT));
        wm = bus.io_wr ? FULL_WMASK : (8'h01 << bus.io_bit);
        wv = bus.io_wr ? bus.io_wdata : (bus.io_bset ? FULL_WMASK : 8'h00);
        strobe_hit = wr_any && ea == CTRL_ADDR && wm[CTRL_WR_BIT] && wv[CTRL_WR_BIT];
        read_hit = wr_any && ea == CTRL_ADDR && wm[CTRL_RD_BIT] && wv[CTRL_RD_BIT];
        start = strobe_hit && write_arm_bit && !busy
              && program_operation_select != PM_RSVD;
    end

    // Register group on the system reset.
    always_comb
    begin
        next_program_operation_select = program_operation_select;
        next_rdy_int_en = rdy_int_en;
        next_write_arm_bit = write_arm_bit;
        next_arm_cnt = (arm_cnt != 3'h0) ? arm_cnt - 3'h1 : 3'h0;
        next_nvm_data_byte = nvm_data_byte;
        next_temp_byte = temp_byte;
        next_done_flag = done_flag;
        next_stall_cnt = (stall_cnt != 3'h0) ? stall_cnt - 3'h1 : 3'h0;
        next_rdata = rdata;
        if (write_arm_bit && arm_cnt == 3'h0)
            next_write_arm_bit = 1'b0;
        if (bus.io_rd)
        begin
            case (ea)
                CTRL_ADDR:      next_rdata = {2'b00, program_operation_select, rdy_int_en,
                                              write_arm_bit, busy, 1'b0};
                DATA_ADDR:      next_rdata = nvm_data_byte;
                ADDR_LOW_ADDR:
                begin
                    next_rdata = nvm_byte_address[7:0];
                    next_temp_byte = {6'b000000, nvm_byte_address[9:8]};
                end
                ADDR_HIGH_ADDR: next_rdata = temp_byte;
                TEMP_ADDR:      next_rdata = temp_byte;
                STAT_ADDR:      next_rdata = {7'b0000000, done_flag};
                default:        next_rdata = 8'h00;
            endcase
        end
        if (wr_any)
        begin
            case (ea)
                CTRL_ADDR:
                begin
                    for (int i = 0; i < 2; i++)
                    begin
                        if (wm[CTRL_PM_LSB+i] && !busy)
                            next_program_operation_select[i] = wv[CTRL_PM_LSB+i];
                    end
                    if (wm[CTRL_IE_BIT])
                        next_rdy_int_en = wv[CTRL_IE_BIT];
                    if (wm[CTRL_ARM_BIT])
                    begin
                        next_write_arm_bit = wv[CTRL_ARM_BIT];
                        next_arm_cnt = ARM_CYCLES - 3'h1;
                    end
                    if (start)
                        next_stall_cnt = WRITE_STALL;
                    else if (read_hit && !busy)
                    begin
                        next_nvm_data_byte = mem[nvm_byte_address[AW-1:0]];
                        next_stall_cnt = READ_STALL;
                    end
                end
                DATA_ADDR:      next_nvm_data_byte = wv;
                ADDR_LOW_ADDR:  next_temp_byte = wv;
                TEMP_ADDR:      next_temp_byte = wv;
                STAT_ADDR:
                begin
                    if (wv[STAT_DONE_BIT])
                        next_done_flag = 1'b0;
                end
                default:        next_temp_byte = next_temp_byte;
            endcase
        end
        if (commit)
            next_done_flag = 1'b1;
        next_stall = next_stall_cnt != 3'h0;
    end

    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            program_operation_select <= PM_ATOMIC;
            rdy_int_en               <= 1'b0;
            write_arm_bit            <= 1'b0;
            arm_cnt                  <= 3'h0;
            nvm_data_byte            <= DATA_RESET;
            temp_byte                <= 8'h00;
            done_flag                <= 1'b0;
            stall_cnt                <= 3'h0;
            stall                    <= 1'b0;
            rdata                    <= 8'h00;
        end
        else
        begin
            program_operation_select <= next_program_operation_select;
            rdy_int_en               <= next_rdy_int_en;
            write_arm_bit            <= next_write_arm_bit;
            arm_cnt                  <= next_arm_cnt;
            nvm_data_byte            <= next_nvm_data_byte;
            temp_byte                <= next_temp_byte;
            done_flag                <= next_done_flag;
            stall_cnt                <= next_stall_cnt;
            stall                    <= next_stall;
            rdata                    <= next_rdata;
        end
    end

    // The address has no reset value; software loads it before any access.
    always_comb
    begin
        next_nvm_byte_address = nvm_byte_address;
        if (wr_any && ea == ADDR_HIGH_ADDR && !busy)
            next_nvm_byte_address = {wv[1:0], temp_byte};
    end

    always_ff @(posedge core_clk_in)
    begin
        nvm_byte_address <= next_nvm_byte_address;
    end

    // Write engine; only the power-on reset stops it.
    always_comb
    begin
        next_busy   = busy;
        next_tcnt   = tcnt;
        next_w_addr = w_addr;
        next_w_data = w_data;
        next_w_mode = w_mode;
        commit      = 1'b0;
        if (busy)
        begin
            if (tcnt == '0)
            begin
                next_busy = 1'b0;
                commit = 1'b1;
            end
            else
                next_tcnt = tcnt - 1'b1;
        end
        if (start)
        begin
            next_busy   = 1'b1;
            next_w_addr = nvm_byte_address[AW-1:0];
            next_w_data = nvm_data_byte;
            next_w_mode = program_operation_select;
            next_tcnt   = (program_operation_select == PM_ATOMIC)
                        ? TIMER_W'(ATOMIC_TICKS - 1) : TIMER_W'(SPLIT_TICKS - 1);
        end
    end

    always_ff @(posedge core_clk_in or negedge por_resetn_in)
    begin
        if (!por_resetn_in)
        begin
            busy   <= 1'b0;
            tcnt   <= '0;
            w_addr <= '0;
            w_data <= 8'h00;
            w_mode <= PM_ATOMIC;
        end
        else
        begin
            busy   <= next_busy;
            tcnt   <= next_tcnt;
            w_addr <= next_w_addr;
            w_data <= next_w_data;
            w_mode <= next_w_mode;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (commit)
        begin
            case (w_mode)
                PM_ERASE: mem[w_addr] <= ERASED_BYTE;
                PM_PROG:  mem[w_addr] <= mem[w_addr] & w_data;
                default:  mem[w_addr] <= w_data;
            endcase
        end
    end
endmodule : nvbap_device
`default_nettype wire

// >>> hdl/nvbap_if.sv
/*
  Byte-wide I/O register bus between the processor-side end and the
  EEPROM access port. Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface nvbap_if;
    logic       io_rd;
    logic       io_wr;
    logic       io_bset;
    logic       io_bclr;
    logic       io_space;
    logic [7:0] io_addr;
    logic [7:0] io_wdata;
    logic [2:0] io_bit;
    logic [7:0] io_rdata;
    logic       io_stall;

    modport device (
        input  io_rd, io_wr, io_bset, io_bclr, io_space, io_addr, io_wdata, io_bit,
        output io_rdata, io_stall
    );
    modport core (
        output io_rd, io_wr, io_bset, io_bclr, io_space, io_addr, io_wdata, io_bit,
        input  io_rdata, io_stall
    );
endinterface : nvbap_if
`default_nettype wire

// >>> hdl/nvbap_pkg.sv
/*
  Shared constants, types and decode functions for the byte access port
  of the on-chip data EEPROM and for the processor-side end that drives it.
  Assumes one 100 MHz core clock shared by both ends.
*/
`default_nettype none
package nvbap_pkg;
    localparam int         CLK_PERIOD_NS   = 10;
    localparam int         ATOMIC_TIME_NS  = 3_400_000;
    localparam int         SPLIT_TIME_NS   = 1_800_000;
    localparam int         ATOMIC_CYCLES   = (ATOMIC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         SPLIT_CYCLES    = (SPLIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         TIMER_W         = 20;
    localparam int         ADDR_W          = 10;
    localparam int         DEFAULT_DEPTH   = 512;
    localparam logic [2:0] ARM_CYCLES      = 3'h4;
    localparam logic [2:0] READ_STALL      = 3'h4;
    localparam logic [2:0] WRITE_STALL     = 3'h2;
    localparam logic [7:0] IO_DATA_OFFSET  = 8'h20;
    localparam logic [7:0] BIT_OP_LIMIT    = 8'h20;
    localparam logic [7:0] CTRL_ADDR       = 8'h3F;
    localparam logic [7:0] DATA_ADDR       = 8'h40;
    localparam logic [7:0] ADDR_LOW_ADDR   = 8'h41;
    localparam logic [7:0] ADDR_HIGH_ADDR  = 8'h42;
    localparam logic [7:0] TEMP_ADDR       = 8'h43;
    localparam logic [7:0] STAT_ADDR       = 8'h44;
    localparam int         CTRL_RD_BIT     = 0;
    localparam int         CTRL_WR_BIT     = 1;
    localparam int         CTRL_ARM_BIT    = 2;
    localparam int         CTRL_IE_BIT     = 3;
    localparam int         CTRL_PM_LSB     = 4;
    localparam int         STAT_DONE_BIT   = 0;
    localparam logic [7:0] DATA_RESET      = 8'h00;
    localparam logic [7:0] ERASED_BYTE     = 8'hFF;
    localparam logic [7:0] CTRL_WMASK      = 8'h3F;
    localparam logic [7:0] ADDR_HIGH_WMASK = 8'h03;
    localparam logic [7:0] STAT_WMASK      = 8'h01;
    localparam logic [7:0] FULL_WMASK      = 8'hFF;

    typedef enum logic [1:0] {
        PM_ATOMIC = 2'b00,
        PM_ERASE  = 2'b01,
        PM_PROG   = 2'b10,
        PM_RSVD   = 2'b11
    } nvbap_pm_t;

    typedef enum logic [1:0] {
        ACC_RD   = 2'b00,
        ACC_WR   = 2'b01,
        ACC_BSET = 2'b10,
        ACC_BCLR = 2'b11
    } nvbap_acc_t;

    typedef enum logic [1:0] {
        CS_IDLE = 2'b00,
        CS_ONE  = 2'b01,
        CS_TWO  = 2'b10
    } nvbap_core_state_t;

    function automatic logic [7:0] nvbap_eff_addr(input logic [7:0] addr, input logic io_space);
        nvbap_eff_addr = io_space ? addr + IO_DATA_OFFSET : addr;
    endfunction : nvbap_eff_addr

    function automatic logic nvbap_mapped(input logic [7:0] ea);
        nvbap_mapped = (ea >= CTRL_ADDR) && (ea <= STAT_ADDR);
    endfunction : nvbap_mapped

    function automatic logic [7:0] nvbap_wmask(input logic [7:0] ea);
        case (ea)
            CTRL_ADDR:      nvbap_wmask = CTRL_WMASK;
            ADDR_HIGH_ADDR: nvbap_wmask = ADDR_HIGH_WMASK;
            STAT_ADDR:      nvbap_wmask = STAT_WMASK;
            default:        nvbap_wmask = FULL_WMASK;
        endcase
    endfunction : nvbap_wmask
endpackage : nvbap_pkg
`default_nettype wire

// >>> sim/nvbap_checker.sv
/* Bus assertions between the two ends of the byte access port.
   Assumes one core clock and the active-low system reset. */
`timescale 1ns/1ps
`default_nettype none
module nvbap_checker
    import nvbap_pkg::*;
(
    input wire logic       core_clk_in,
    input wire logic       resetn_in,
    input wire logic       io_rd,
    input wire logic       io_wr,
    input wire logic       io_bset,
    input wire logic       io_bclr,
    input wire logic       io_space,
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic [2:0] io_bit,
    input wire logic [7:0] io_rdata,
    input wire logic       io_stall
);
    logic [7:0] eff;
    assign eff = io_space ? io_addr + IO_DATA_OFFSET : io_addr;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    sequence stall4_s; io_stall [*4] ##1 !io_stall; endsequence
    sequence stall2_s; io_stall [*2] ##1 !io_stall; endsequence
    one_access_a: assert property ($onehot0({io_rd, io_wr, io_bset, io_bclr}))
        else $error("two bus accesses in one cycle");
    stall_quiet_a: assert property (io_stall |-> !(io_rd || io_wr || io_bset || io_bclr))
        else $error("access issued during stall");
    read_stall_a: assert property ($rose(io_stall) && $past(io_wr && io_wdata[1:0] == 2'b01) |-> stall4_s)
        else $error("read stall length wrong");
    write_stall_a: assert property ($rose(io_stall) && $past(io_bset && io_bit == 3'h1) |-> stall2_s)
        else $error("write stall length wrong");
    stall_cause_a: assert property ($rose(io_stall) |-> $past((io_wr || io_bset) && eff == CTRL_ADDR))
        else $error("stall without control access");
    rdata_hold_a: assert property ($changed(io_rdata) |-> $past(io_rd))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property (io_rd && (eff < CTRL_ADDR || eff > STAT_ADDR) |=> io_rdata == 8'h00)
        else $error("unmapped read not zero");
    ctrl_read_a: assert property (io_rd && eff == CTRL_ADDR |=> io_rdata[7:6] == 2'b00 && !io_rdata[0])
        else $error("control reserved bits not zero");
    stat_read_a: assert property (io_rd && eff == STAT_ADDR |=> io_rdata[7:1] == 7'h00)
        else $error("status reserved bits not zero");
endmodule : nvbap_checker
`default_nettype wire

// >>> sim/tb.sv
/* Bench joining both ends through the bus interface, driven at the command port.
   Assumes a 100 MHz core clock and short write timing parameters. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import nvbap_pkg::*;
    logic        core_clk_in = 0, resetn_in = 0, por_resetn_in = 0, cmd_valid_in = 0;
    logic        cmd_wide_in = 0, cmd_io_in = 0, cmd_ready_out, rsp_valid_out, nvm_busy_out;
    logic [1:0]  cmd_kind_in = 0;
    logic [2:0]  cmd_bit_in = 0;
    logic [7:0]  cmd_addr_in = 0, d;
    logic [9:0]  ad;
    logic [15:0] cmd_wdata_in = 0, rsp_data_out, r;
    logic [31:0] seed = 32'h0CA0;
    int          n_fail = 0, cmp_count = 0, cycles = 0, mem[int];
    nvbap_if bus_if();
    nvbap_device #(.DEPTH(512), .ATOMIC_TICKS(20), .SPLIT_TICKS(10)) nvbap_device_inst (
        .core_clk_in(core_clk_in), .resetn_in(resetn_in), .por_resetn_in(por_resetn_in),
        .bus(bus_if.device), .nvm_busy_out(nvm_busy_out));
    nvbap_core nvbap_core_inst (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
        .bus(bus_if.core), .cmd_valid_in(cmd_valid_in), .cmd_kind_in(cmd_kind_in),
        .cmd_wide_in(cmd_wide_in), .cmd_io_in(cmd_io_in), .cmd_addr_in(cmd_addr_in),
        .cmd_wdata_in(cmd_wdata_in), .cmd_bit_in(cmd_bit_in), .cmd_ready_out(cmd_ready_out),
        .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out));
    nvbap_checker nvbap_checker_inst (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
        .io_rd(bus_if.io_rd), .io_wr(bus_if.io_wr), .io_bset(bus_if.io_bset),
        .io_bclr(bus_if.io_bclr), .io_space(bus_if.io_space), .io_addr(bus_if.io_addr),
        .io_wdata(bus_if.io_wdata), .io_bit(bus_if.io_bit), .io_rdata(bus_if.io_rdata),
        .io_stall(bus_if.io_stall));
    initial
    begin
        forever #5 core_clk_in = ~core_clk_in;
    end
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : rnd
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Called at a falling edge; I/O space is chosen at random where allowed.
    task automatic cmd(input logic [1:0] k, input logic w, input logic [7:0] a,
                       input logic [15:0] v, output logic [15:0] q);
        void'(rnd());
        cmd_io_in = k[1] | seed[0];
        cmd_addr_in = cmd_io_in ? a - 8'h20 : a;
        {cmd_valid_in, cmd_kind_in, cmd_wide_in, cmd_wdata_in, cmd_bit_in} = {1'b1, k, w, v, v[2:0]};
        while (cmd_ready_out !== 1'b1) @(negedge core_clk_in);
        @(negedge core_clk_in);
        cmd_valid_in = 0;
        while (rsp_valid_out !== 1'b1) @(negedge core_clk_in);
        q = rsp_data_out;
    endtask : cmd
    task automatic finish_write(input logic done);
        do cmd(0, 0, 8'h3F, 16'h0000, r); while (r[1] !== 1'b0);
        cmd(0, 0, 8'h44, 16'h0000, r);
        check({8'h00, r[7:0]}, {15'h0000, done});
        cmd(1, 0, 8'h44, 16'h0001, r);
        cmd(0, 0, 8'h44, 16'h0000, r);
        check({8'h00, r[7:0]}, 16'h0000);
        cmd(1, 1, 8'h41, {6'h00, ad}, r);
        cmd(1, 0, 8'h3F, 16'h0001, r);
        cmd(0, 0, 8'h40, 16'h0000, r);
        check({8'h00, r[7:0]}, 16'(mem[ad[8:0]]));
    endtask : finish_write
    always @(posedge core_clk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            end_of_test();
        end
    end
    initial
    begin
        repeat (5) @(posedge core_clk_in);
        @(negedge core_clk_in);
        {resetn_in, por_resetn_in} = 2'b11;
        @(negedge core_clk_in);
        repeat (3)
        begin
            ad = 10'(rnd());
            cmd(1, 1, 8'h41, {6'h00, ad}, r);
            cmd(0, 1, 8'h41, 16'h0000, r);
            check(r, {6'h00, ad});
        end
        for (int m = 0; m < 4; m++)
        begin
            d = 8'(rnd());
            cmd(1, 0, 8'h40, {8'h00, d}, r);
            cmd(1, 0, 8'h3F, 16'(m * 16 + 4), r);
            cmd(2, 0, 8'h3F, 16'h0001, r);
            check({15'h0000, nvm_busy_out}, {15'h0000, m != 3});
            if (m == 0) mem[ad[8:0]] = d;
            else if (m == 1) mem[ad[8:0]] = 255;
            else if (m == 2) mem[ad[8:0]] = mem[ad[8:0]] & d;
            finish_write(m != 3);
        end
        cmd(1, 0, 8'h3F, 16'h0004, r);
        repeat (8) @(negedge core_clk_in);
        cmd(2, 0, 8'h3F, 16'h0001, r);
        cmd(0, 0, 8'h3F, 16'h0000, r);
        check({8'h00, r[7:0]}, 16'h0000);
        cmd(2, 0, 8'h3F, 16'h0003, r);
        cmd(0, 0, 8'h3F, 16'h0000, r);
        check({8'h00, r[7:0]}, 16'h0008);
        cmd(3, 0, 8'h3F, 16'h0003, r);
        cmd(0, 0, 8'h3F, 16'h0000, r);
        check({8'h00, r[7:0]}, 16'h0000);
        cmd(1, 0, 8'h50, 16'h00A5, r);
        cmd(0, 0, 8'h50, 16'h0000, r);
        check({8'h00, r[7:0]}, 16'h0000);
        d = 8'(rnd());
        cmd(1, 0, 8'h43, {8'h00, d}, r);
        cmd(0, 0, 8'h43, 16'h0000, r);
        check({8'h00, r[7:0]}, {8'h00, d});
        cmd(1, 0, 8'h40, {8'h00, d}, r);
        cmd(1, 0, 8'h3F, 16'h0004, r);
        cmd(2, 0, 8'h3F, 16'h0001, r);
        resetn_in = 0;
        repeat (2) @(negedge core_clk_in);
        resetn_in = 1;
        @(negedge core_clk_in);
        mem[ad[8:0]] = d;
        finish_write(1);
        end_of_test();
    end
endmodule : tb
`default_nettype wire
